// ---- include/ufr_pkg.sv ----
// Package for the USB function interrupt and transfer-request routing block.
// Assumes a 32-bit AXI4-Lite register bus on a single 10 MHz clock.
package ufr_pkg;

  // ********************************
  // Register byte offsets
  // ********************************
  localparam logic [7:0] UFR_IFR0_OFF = 8'h00;
  localparam logic [7:0] UFR_IFR0_CLR_OFF = 8'h04;
  localparam logic [7:0] UFR_IFR0_EN_A_OFF = 8'h08;
  localparam logic [7:0] UFR_IFR0_EN_B_OFF = 8'h0C;
  localparam logic [7:0] UFR_XFER_SET_OFF = 8'h10;
  localparam logic [7:0] UFR_XFER_END_OFF = 8'h14;
  localparam logic [7:0] UFR_XFER_END_CLR_OFF = 8'h18;
  localparam logic [7:0] UFR_XFER_END_EN_OFF = 8'h1C;
  localparam logic [7:0] UFR_DMA_OP_OFF = 8'h20;
  localparam logic [7:0] UFR_DTC_EN_OFF = 8'h24;

  // ********************************
  // Field positions
  // ********************************
  localparam int UFR_BUS_RESET_BIT = 7;
  localparam int UFR_RX_FULL_BIT = 6;
  localparam int UFR_TX_TREQ_BIT = 5;
  localparam int UFR_TX_EMPTY_BIT = 4;
  localparam int UFR_TX_ARM_BIT = 0;
  localparam int UFR_RX_ARM_BIT = 1;
  localparam int UFR_TX_END_BIT = 0;
  localparam int UFR_RX_END_BIT = 1;
  localparam int UFR_DME_BIT = 0;
  localparam int UFR_DTC0_BIT = 0;
  localparam int UFR_DTC1_BIT = 1;

  // ********************************
  // Reset values and answers
  // ********************************
  localparam logic [7:0] UFR_FLAG_RST = 8'h00;
  localparam logic [1:0] UFR_RESP_OKAY = 2'h0;
  localparam logic [1:0] UFR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UFR_WR_IDLE = 2'b00,
    UFR_WR_RESP = 2'b01
  } ufr_wr_state_t;

endpackage : ufr_pkg

// ---- design/ufr_sticky_flags.sv ----
// Bank of sticky flags: set by hardware events, cleared by write-one.
// Assumes set and clear strobes are on the same clock as the bank.
`timescale 1ns/1ps
`default_nettype none

module ufr_sticky_flags #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] flags_ff
);

  // Refused while the design is elaborated, before any clock runs
  if (WIDTH < 1) begin : g_bad_width
    $error("ufr_sticky_flags: WIDTH must be at least 1");
  end

  wire logic [WIDTH-1:0] nxt_flags;

  // Set wins over a clear arriving in the same cycle, so no event is lost
  assign nxt_flags = (flags_ff & ~clr_i) | set_i;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule : ufr_sticky_flags

`default_nettype wire

// ---- design/ufr_irq_route.sv ----
// USB function interrupt-source and transfer-request routing with AXI4-Lite registers.
// Assumes event strobes from the USB core are one-cycle pulses on aclk.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Bus reset flag bit 7, interrupt only
// - Rx FIFO full flag bit 6, receive request
// - Tx transfer request flag bit 5, interrupt only
// - Tx FIFO empty flag bit 4, transmit request
// - Tx armed without DMA/DTC0 sets tx end
// - Rx armed without DMA/DTC1 sets rx end
module ufr_irq_route
  import ufr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_reset_evt,
  input wire logic rx_fifo_full_evt,
  input wire logic tx_treq_evt,
  input wire logic tx_fifo_empty_evt,
  output logic usb_irq_line_a,
  output logic usb_irq_line_b,
  output logic usb_rx_transfer_request,
  output logic usb_tx_transfer_request,
  output logic usb_xfer_end_irq
);

  // ********************************
  // Write channel
  // ********************************
  logic [7:0] wr_addr_ff;
  logic aw_held_ff;
  logic [31:0] wr_data_ff;
  logic [3:0] wr_strb_ff;
  logic w_held_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  wire logic aw_fire = s_axi_awvalid && s_axi_awready;
  wire logic w_fire = s_axi_wvalid && s_axi_wready;
  wire logic have_aw = aw_held_ff || aw_fire;
  wire logic have_w = w_held_ff || w_fire;
  wire logic wr_go = have_aw && have_w && !bvalid_ff;
  wire logic [7:0] wr_addr = aw_held_ff ? wr_addr_ff : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_ff ? wr_data_ff : s_axi_wdata;
  wire logic [3:0] wr_strb = w_held_ff ? wr_strb_ff : s_axi_wstrb;
  wire logic [7:0] wbyte = wr_strb[0] ? wr_data[7:0] : 8'h00;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  wire logic wr_ifr0_clr = wr_go && wr_addr == UFR_IFR0_CLR_OFF;
  wire logic wr_en_a = wr_go && wr_addr == UFR_IFR0_EN_A_OFF && wr_strb[0];
  wire logic wr_en_b = wr_go && wr_addr == UFR_IFR0_EN_B_OFF && wr_strb[0];
  wire logic wr_xset = wr_go && wr_addr == UFR_XFER_SET_OFF && wr_strb[0];
  wire logic wr_end_clr = wr_go && wr_addr == UFR_XFER_END_CLR_OFF;
  wire logic wr_end_en = wr_go && wr_addr == UFR_XFER_END_EN_OFF && wr_strb[0];
  wire logic wr_dma = wr_go && wr_addr == UFR_DMA_OP_OFF && wr_strb[0];
  wire logic wr_dtc = wr_go && wr_addr == UFR_DTC_EN_OFF && wr_strb[0];
  wire logic wr_mapped = wr_addr == UFR_IFR0_OFF || wr_addr == UFR_IFR0_CLR_OFF
    || wr_addr == UFR_IFR0_EN_A_OFF || wr_addr == UFR_IFR0_EN_B_OFF
    || wr_addr == UFR_XFER_SET_OFF || wr_addr == UFR_XFER_END_OFF
    || wr_addr == UFR_XFER_END_CLR_OFF || wr_addr == UFR_XFER_END_EN_OFF
    || wr_addr == UFR_DMA_OP_OFF || wr_addr == UFR_DTC_EN_OFF;
  // Status registers are read-only; a write there gets an error answer
  wire logic wr_ok = wr_mapped && wr_addr != UFR_IFR0_OFF && wr_addr != UFR_XFER_END_OFF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end else if (aw_fire) begin
      aw_held_ff <= 1'b1;
      wr_addr_ff <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wr_data_ff <= 32'h0000_0000;
      wr_strb_ff <= 4'h0;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end else if (w_fire) begin
      w_held_ff <= 1'b1;
      wr_data_ff <= s_axi_wdata;
      wr_strb_ff <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= UFR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_ok ? UFR_RESP_OKAY : UFR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ********************************
  // Control registers
  // ********************************
  logic [7:0] en_a_ff;
  logic [7:0] en_b_ff;
  logic [1:0] xset_ff;
  logic [1:0] end_en_ff;
  logic dme_ff;
  logic [1:0] dtc_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_a_ff <= UFR_FLAG_RST;
      en_b_ff <= UFR_FLAG_RST;
      xset_ff <= 2'h0;
      end_en_ff <= 2'h0;
      dme_ff <= 1'b0;
      dtc_ff <= 2'h0;
    end else begin
      if (wr_en_a) en_a_ff <= wbyte;
      if (wr_en_b) en_b_ff <= wbyte;
      if (wr_xset) xset_ff <= wbyte[1:0];
      if (wr_end_en) end_en_ff <= wbyte[1:0];
      if (wr_dma) dme_ff <= wbyte[UFR_DME_BIT];
      if (wr_dtc) dtc_ff <= wbyte[1:0];
    end
  end

  // ********************************
  // Flags and routing
  // ********************************
  logic [7:0] ifr0_ff;
  logic [1:0] xend_ff;
  wire logic [7:0] ifr0_set;
  wire logic [1:0] xend_set;

  assign ifr0_set[UFR_BUS_RESET_BIT] = bus_reset_evt;
  assign ifr0_set[UFR_RX_FULL_BIT] = rx_fifo_full_evt;
  assign ifr0_set[UFR_TX_TREQ_BIT] = tx_treq_evt;
  assign ifr0_set[UFR_TX_EMPTY_BIT] = tx_fifo_empty_evt;
  assign ifr0_set[3:0] = 4'h0;

  // Arming with neither DMA nor its own DTC channel enabled ends the transfer at once; the
  // enable is checked on the arming write, relying on software to order it.
  wire logic tx_arm_now = wr_xset && wbyte[UFR_TX_ARM_BIT];
  wire logic rx_arm_now = wr_xset && wbyte[UFR_RX_ARM_BIT];
  assign xend_set[UFR_TX_END_BIT] = tx_arm_now && !dme_ff && !dtc_ff[UFR_DTC0_BIT];
  assign xend_set[UFR_RX_END_BIT] = rx_arm_now && !dme_ff && !dtc_ff[UFR_DTC1_BIT];

  ufr_sticky_flags #(.WIDTH(8)) u_ifr0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_i(ifr0_set),
    .clr_i(wr_ifr0_clr ? wbyte : 8'h00),
    .flags_ff(ifr0_ff)
  );

  ufr_sticky_flags #(.WIDTH(2)) u_xend (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_i(xend_set),
    .clr_i(wr_end_clr ? wbyte[1:0] : 2'h0),
    .flags_ff(xend_ff)
  );

  // Bits 3:0 never set, so they never reach the lines
  assign usb_irq_line_a = |(ifr0_ff & en_a_ff);
  assign usb_irq_line_b = |(ifr0_ff & en_b_ff);
  // Only full and empty flags request transfers; bus reset and tx request do not
  assign usb_rx_transfer_request = ifr0_ff[UFR_RX_FULL_BIT] && xset_ff[UFR_RX_ARM_BIT];
  assign usb_tx_transfer_request = ifr0_ff[UFR_TX_EMPTY_BIT] && xset_ff[UFR_TX_ARM_BIT];
  assign usb_xfer_end_irq = |(xend_ff & end_en_ff);

  // ********************************
  // Read channel
  // ********************************
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rsel;
  logic rhit;

  always_comb begin
    rsel = 8'h00;
    rhit = 1'b1;
    case (s_axi_araddr)
      UFR_IFR0_OFF: rsel = ifr0_ff;
      UFR_IFR0_CLR_OFF: rsel = 8'h00;
      UFR_IFR0_EN_A_OFF: rsel = en_a_ff;
      UFR_IFR0_EN_B_OFF: rsel = en_b_ff;
      UFR_XFER_SET_OFF: rsel = {6'h00, xset_ff};
      UFR_XFER_END_OFF: rsel = {6'h00, xend_ff};
      UFR_XFER_END_CLR_OFF: rsel = 8'h00;
      UFR_XFER_END_EN_OFF: rsel = {6'h00, end_en_ff};
      UFR_DMA_OP_OFF: rsel = {7'h00, dme_ff};
      UFR_DTC_EN_OFF: rsel = {6'h00, dtc_ff};
      default: rhit = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= UFR_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h000000, rsel};
      rresp_ff <= rhit ? UFR_RESP_OKAY : UFR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule : ufr_irq_route

`default_nettype wire

// ---- verification/ufr_irq_route_sva.sv ----
// Checker for the USB routing block: bus answers, the causes of the request and end outputs, and line a holding.
// Bound to ufr_irq_route; sees its ports only, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ufr_irq_route_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_fifo_full_evt,
  input wire logic tx_fifo_empty_evt,
  input wire logic usb_irq_line_a,
  input wire logic usb_rx_transfer_request,
  input wire logic usb_tx_transfer_request,
  input wire logic usb_xfer_end_irq
);
  logic wr_fire;
  assign wr_fire = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid held");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid held");
  property p_b_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
  a_b_ans: assert property (p_b_ans) else $error("no write answer");
  property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("no read answer");
  property p_rx_rise; $rose(usb_rx_transfer_request) |-> $past(rx_fifo_full_evt || wr_fire); endproperty
  a_rx_rise: assert property (p_rx_rise) else $error("rx request without cause");
  property p_tx_rise; $rose(usb_tx_transfer_request) |-> $past(tx_fifo_empty_evt || wr_fire); endproperty
  a_tx_rise: assert property (p_tx_rise) else $error("tx request without cause");
  property p_end_rise; $rose(usb_xfer_end_irq) |-> $past(wr_fire); endproperty
  a_end_rise: assert property (p_end_rise) else $error("end irq without write");
  property p_irq_hold; usb_irq_line_a && !wr_fire |=> usb_irq_line_a; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule : ufr_irq_route_sva
bind ufr_irq_route ufr_irq_route_sva ufr_irq_route_sva_inst (.*);
`default_nettype wire

// ---- verification/ufr_usb_model.sv ----
// Far-side model: the USB core raising one-cycle event strobes on request.
// Assumes the bench asks for a delay of 0 to 3 cycles with each request.
`timescale 1ns/1ps
`default_nettype none
module ufr_usb_model (
  input wire logic aclk,
  input wire logic [3:0] req,
  input wire logic [1:0] dly,
  output logic [3:0] usb_evt = 4'h0
);
  logic [3:0] pend_ff = 4'h0;
  logic [1:0] cnt_ff = 2'h0;
  // A late strobe mimics a slow core
  always_ff @(posedge aclk) begin
    usb_evt <= (cnt_ff == 2'h0) ? pend_ff : 4'h0;
    pend_ff <= (req != 4'h0) ? req : (cnt_ff == 2'h0 ? 4'h0 : pend_ff);
    cnt_ff <= (req != 4'h0) ? dly : cnt_ff - {1'b0, cnt_ff != 2'h0};
  end
endmodule : ufr_usb_model
`default_nettype wire

// ---- verification/ufr_irq_route_tb.sv ----
// Bench: register bus master, event model and output checks for the routing block.
// Assumes the register map of the package and a synchronous low reset.
`timescale 1ns/1ps
`default_nettype none
module ufr_irq_route_tb;
  import ufr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, req = 4'h0, evt;
  logic [1:0] dly = 2'h0, s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic usb_irq_line_a, usb_irq_line_b, usb_rx_transfer_request, usb_tx_transfer_request, usb_xfer_end_irq;
  logic [4:0] o;
  logic [33:0] q[$];
  int err_count = 0, n_tests = 0, seed = 65;
  assign o = {usb_irq_line_a, usb_irq_line_b, usb_rx_transfer_request, usb_tx_transfer_request, usb_xfer_end_irq};
  ufr_irq_route ufr_irq_route_inst (.*, .bus_reset_evt(evt[3]), .rx_fifo_full_evt(evt[2]),
    .tx_treq_evt(evt[1]), .tx_fifo_empty_evt(evt[0]));
  ufr_usb_model ufr_usb_model_inst (.aclk(aclk), .req(req), .dly(dly), .usb_evt(evt));
  initial forever #50 aclk = ~aclk;
  task chk(input logic [33:0] s, input logic [33:0] w);
    n_tests++;
    err_count += int'(s !== w);
    if (s !== w) $display("unexpected at %0t: got %h, expected %h", $time, s, w);
  endtask : chk
  task bus(input logic w, input logic [7:0] a, d, input logic [1:0] e);
    logic [2:0] t;
    q.push_back({e, w ? 32'h0 : {24'h0, d}});
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'($random(seed)), d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    do begin
      @(negedge aclk);
      t = {s_axi_awready & s_axi_awvalid | s_axi_arready & s_axi_arvalid,
        s_axi_wready & s_axi_wvalid, s_axi_bvalid | s_axi_rvalid};
      @(posedge aclk);
      if (t[2]) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (t[1]) s_axi_wvalid <= 1'b0;
    end while (!t[0]);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask : bus
  task fire(input logic [3:0] v);
    @(posedge aclk);
    {req, dly} <= {v, 2'($random(seed))};
    @(posedge aclk);
    req <= 4'h0;
    do @(negedge aclk); while (evt == 4'h0);
    @(negedge aclk);
  endtask : fire
  task report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  always @(negedge aclk) if (s_axi_bvalid | s_axi_rvalid)
    chk(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, q.pop_front());
  initial begin
    #300000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) bus(1'b0, 8'(4 * i), 8'h00, 2'h0);
    for (int i = 0; i < 3; i++) bus(1'b1, 8'(20 * i), 8'h00, 2'h2);
    bus(1'b0, 8'h28, 8'h00, 2'h2);
    // The DMA enable goes in before the arm bits, so arming raises no end flag
    bus(1'b1, 8'h20, 8'h01, 2'h0);
    bus(1'b1, 8'h10, 8'h03, 2'h0);
    bus(1'b1, 8'h08, 8'hF0, 2'h0);
    bus(1'b1, 8'h0C, 8'h80, 2'h0);
    for (int k = 0; k < 4; k++) begin
      fire(4'h1 << k);
      chk({29'h0, o}, {29'h0, 1'b1, k == 3, k == 2, k == 0, 1'b0});
      bus(1'b0, 8'h00, 8'h10 << k, 2'h0);
      bus(1'b1, 8'h04, 8'h10 << k, 2'h0);
      chk({29'h0, o}, 34'h0);
    end
    fire(4'hF);
    bus(1'b1, 8'h08, 8'h00, 2'h0);
    chk({29'h0, o}, 34'hE);
    bus(1'b0, 8'h00, 8'hF0, 2'h0);
    bus(1'b1, 8'h1C, 8'h03, 2'h0);
    for (int j = 0; j < 5; j++) begin
      bus(1'b1, 8'h20, 8'(j >> 2), 2'h0);
      bus(1'b1, 8'h24, 8'(j & 3), 2'h0);
      bus(1'b1, 8'h10, 8'h03, 2'h0);
      bus(1'b0, 8'h14, j > 3 ? 8'h00 : 8'(~j & 3), 2'h0);
      chk({33'h0, usb_xfer_end_irq}, {33'h0, j < 3});
      bus(1'b1, 8'h18, 8'h03, 2'h0);
    end
    // Lane 0 off: the write is answered but leaves the line b enable as it was
    s_axi_wstrb <= 4'hE;
    bus(1'b1, 8'h0C, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hF;
    bus(1'b0, 8'h0C, 8'h80, 2'h0);
    report_and_stop();
  end
endmodule : ufr_irq_route_tb
`default_nettype wire
